// ===== verilog/pcmp_pkg.sv
// shared constants of the position compare output block
package pcmp_pkg;
    localparam int ADDR_W = 16;
    localparam int POINTS = 42;
    localparam int IDX_W = 6;
    localparam int OUTS = 9;
    // register offsets
    localparam logic [15:0] OFS_DIV_SRC = 16'h2544;
    localparam logic [15:0] OFS_CMP_EN = 16'h2570;
    localparam logic [15:0] OFS_CMP_MODE = 16'h2571;
    localparam logic [15:0] OFS_PULSE_W = 16'h2572;
    localparam logic [15:0] OFS_DELAY = 16'h2573;
    localparam logic [15:0] OFS_START_PT = 16'h2574;
    localparam logic [15:0] OFS_END_PT = 16'h2575;
    localparam logic [15:0] OFS_N_CYC = 16'h2576;
    localparam logic [15:0] OFS_CMP_SRC = 16'h257C;
    localparam logic [15:0] OFS_DO_CFG = 16'h257D;
    localparam logic [15:0] OFS_DIV_POL = 16'h257E;
    localparam logic [15:0] OFS_RESTART = 16'h257F;
    localparam logic [15:0] OFS_STATUS = 16'h2580;
    localparam logic [15:0] OFS_CYC_CNT = 16'h2581;
    localparam logic [15:0] OFS_TGT_BASE = 16'h3000;
    localparam logic [15:0] OFS_ATTR_BASE = 16'h3100;
    // reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_PULSE_W = 16'h000A;
    localparam logic [5:0] RST_POINT = 6'h01;
    localparam logic [15:0] RST_N_CYC = 16'h0001;
    // divider source codes
    localparam logic [2:0] DSRC_MOTOR = 3'h0;
    localparam logic [2:0] DSRC_EXT = 3'h1;
    localparam logic [2:0] DSRC_CMD = 3'h3;
    localparam logic [2:0] DSRC_OFF = 3'h4;
    // compare modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_NCYC = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;
    // attribute word fields
    localparam int ATTR_POS = 0;
    localparam int ATTR_NEG = 1;
    localparam int ATTR_FLIP = 6;
    localparam int ATTR_OUT_LSB = 7;
    // control field positions
    localparam int DOCFG_POL_LSB = 6;
    localparam int DIVPOL_ROUTE = 3;
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int PW_UNIT_NS = 100000;
    localparam int DLY_UNIT_NS = 100;
    localparam int PW_UNIT_CYC = PW_UNIT_NS / CLK_PERIOD_NS;
    localparam int DLY_UNIT_CYC = (DLY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : pcmp_pkg

// ===== verilog/pcmp_cross.sv
// crossing detector for one target point
`timescale 1ns/100ps
module pcmp_cross (
    input wire logic signed [31:0] prev_in,
    input wire logic signed [31:0] cur_in,
    input wire logic signed [31:0] target_in,
    input wire logic pos_en_in,
    input wire logic neg_en_in,
    output logic hit_out
);
    wire up_cross = (prev_in < target_in) && (cur_in >= target_in);
    wire dn_cross = (prev_in > target_in) && (cur_in <= target_in);
    // each direction switched on its own
    assign hit_out = (pos_en_in && up_cross) || (neg_en_in && dn_cross);
endmodule : pcmp_cross

// ===== verilog/pcmp_timer.sv
// unit-based interval timer; limit is read live while running
`timescale 1ns/100ps
module pcmp_timer #(
    parameter int UNIT_CYC = 2
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [15:0] limit_in,
    output logic busy_out,
    output logic done_out
);
    logic [22:0] pre_q;
    logic [15:0] units_q;
    logic busy_q;
    logic done_q;
    wire unit_end = (pre_q == 23'(UNIT_CYC - 1));
    wire [15:0] units_nx = units_q + 16'h0001;
    // a lowered limit ends the interval at once
    wire reached = (units_q >= limit_in) || (unit_end && units_nx >= limit_in);
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pre_q <= 23'h000000;
            units_q <= 16'h0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (start_in)
        begin
            pre_q <= 23'h000000;
            units_q <= 16'h0000;
            busy_q <= (limit_in != 16'h0000);
            done_q <= (limit_in == 16'h0000);
        end
        else if (busy_q)
        begin
            pre_q <= unit_end ? 23'h000000 : pre_q + 23'h000001;
            units_q <= unit_end ? units_nx : units_q;
            busy_q <= !reached;
            done_q <= reached;
        end
        else
        begin
            done_q <= 1'b0;
        end
    end
    assign busy_out = busy_q;
    assign done_out = done_q;
endmodule : pcmp_timer

// ===== verilog/pcmp_top.sv
// position compare output unit: register file, point sequencer, output drive
`timescale 1ns/100ps
//
// Summary of operation
// - compare live position with up to 42 target points, fire output on trigger.
// - result drives six digital outputs or divider A/B/Z, each with own polarity.
// - each point selects fixed-width pulse or level flip output.
// - pulse width 0..4095 units of 0.1 ms, new width acts at once.
// - signed delay -10000..10000 of 0.1 us, taken only at restart; only negative values delay, a positive value acts as no delay.
// - comparison source is motor encoder or external encoder position.
// - divider source 0 motor, 1 external, 2 reserved, 3 command, 4 off.
// - comparison unavailable while divider source is command passthrough.
// - divider source change takes effect only at restart.
// - comparison starts on 0-to-1 of enable; 0 keeps it off.
// - modes 0 single pass, 1 repeat N cycles, 2 continuous.
// - crossing trigger, positive and negative direction switched per point.
// - comparison done entirely in logic, no processor in the path.
// - N-cycle mode repeats the sequence 1..50000 times.
// - attribute bit0 positive, bit1 negative, bit6 pulse or flip.
module pcmp_top
    import pcmp_pkg::*;
#(
    parameter int PW_CYC = pcmp_pkg::PW_UNIT_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [pcmp_pkg::ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [31:0] motor_pos_in,
    input wire logic [31:0] ext_pos_in,
    input wire logic [2:0] motor_abz_in,
    input wire logic [2:0] ext_abz_in,
    input wire logic [2:0] cmd_abz_in,
    input wire logic [5:0] do_func_in,
    output logic [5:0] do_out,
    output logic div_a_out,
    output logic div_b_out,
    output logic div_z_out
);
    import pcmp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [2:0] divider_source_select_q;
    logic [2:0] div_src_act_q;
    logic compare_enable_q;
    logic en_prev_q;
    logic [1:0] compare_mode_select_q;
    logic [15:0] compare_pulse_width_q;
    logic [15:0] compare_delay_compensation_q;
    logic [15:0] dly_act_q;
    logic [5:0] start_pt_q;
    logic [5:0] end_pt_q;
    logic [15:0] n_cyc_q;
    logic cmp_src_q;
    logic [11:0] digital_output_function_config_q;
    logic [3:0] divider_output_polarity_q;
    logic [31:0] target_q [POINTS];
    logic [15:0] attr_q [POINTS];
    logic [31:0] rdata_q;

    wire wr_div = wr_in && (addr_in == OFS_DIV_SRC);
    wire wr_en = wr_in && (addr_in == OFS_CMP_EN);
    wire wr_mode = wr_in && (addr_in == OFS_CMP_MODE);
    wire wr_pw = wr_in && (addr_in == OFS_PULSE_W);
    wire wr_dly = wr_in && (addr_in == OFS_DELAY);
    wire wr_start = wr_in && (addr_in == OFS_START_PT);
    wire wr_end = wr_in && (addr_in == OFS_END_PT);
    wire wr_ncyc = wr_in && (addr_in == OFS_N_CYC);
    wire wr_src = wr_in && (addr_in == OFS_CMP_SRC);
    wire wr_docfg = wr_in && (addr_in == OFS_DO_CFG);
    wire wr_divpol = wr_in && (addr_in == OFS_DIV_POL);
    wire restart = wr_in && (addr_in == OFS_RESTART);
    wire [15:0] tgt_rel = addr_in - OFS_TGT_BASE;
    wire [15:0] attr_rel = addr_in - OFS_ATTR_BASE;
    wire tgt_hit = (addr_in >= OFS_TGT_BASE) && (tgt_rel < 16'(POINTS));
    wire attr_hit = (addr_in >= OFS_ATTR_BASE) && (attr_rel < 16'(POINTS));

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            divider_source_select_q <= 3'h0;
            compare_enable_q <= 1'b0;
            compare_mode_select_q <= 2'h0;
            compare_pulse_width_q <= RST_PULSE_W;
            compare_delay_compensation_q <= RST_ZERO;
            start_pt_q <= RST_POINT;
            end_pt_q <= RST_POINT;
            n_cyc_q <= RST_N_CYC;
            cmp_src_q <= 1'b0;
            digital_output_function_config_q <= 12'h000;
            divider_output_polarity_q <= 4'h0;
        end
        else
        begin
            if (wr_div)
                divider_source_select_q <= wdata_in[2:0];
            if (wr_en)
                compare_enable_q <= wdata_in[0];
            if (wr_mode)
                compare_mode_select_q <= wdata_in[1:0];
            if (wr_pw)
                compare_pulse_width_q <= {4'h0, wdata_in[11:0]};
            if (wr_dly)
                compare_delay_compensation_q <= wdata_in[15:0];
            if (wr_start)
                start_pt_q <= wdata_in[5:0];
            if (wr_end)
                end_pt_q <= wdata_in[5:0];
            if (wr_ncyc)
                n_cyc_q <= (wdata_in[15:0] == 16'h0000) ? RST_N_CYC : wdata_in[15:0];
            if (wr_src)
                cmp_src_q <= wdata_in[0];
            if (wr_docfg)
                digital_output_function_config_q <= wdata_in[11:0];
            if (wr_divpol)
                divider_output_polarity_q <= wdata_in[3:0];
        end
    end

    // point table kept without reset: software loads it before enabling
    always_ff @(posedge clk_in)
    begin
        if (wr_in && tgt_hit)
            target_q[tgt_rel[IDX_W-1:0]] <= wdata_in;
        if (wr_in && attr_hit)
            attr_q[attr_rel[IDX_W-1:0]] <= wdata_in[15:0];
    end

    // settings that act only at restart
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            div_src_act_q <= DSRC_MOTOR;
            dly_act_q <= RST_ZERO;
        end
        else if (restart)
        begin
            div_src_act_q <= divider_source_select_q;
            dly_act_q <= compare_delay_compensation_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // position sampling and crossing test
    logic signed [31:0] pos_prev_q;
    logic signed [31:0] pos_cur_q;
    logic active_q;
    logic [5:0] idx_q;
    logic [15:0] cyc_q;
    logic hit;
    wire [31:0] pos_sel = cmp_src_q ? ext_pos_in : motor_pos_in;
    wire [5:0] idx_addr = idx_q - 6'h01;
    wire [15:0] cur_attr = attr_q[idx_addr];
    wire signed [31:0] cur_tgt = target_q[idx_addr];

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pos_prev_q <= 32'h00000000;
            pos_cur_q <= 32'h00000000;
        end
        else
        begin
            pos_cur_q <= pos_sel;
            pos_prev_q <= pos_cur_q;
        end
    end

    // direct compare every clock, no software in the loop
    pcmp_cross u_cross (
        .prev_in(pos_prev_q),
        .cur_in(pos_cur_q),
        .target_in(cur_tgt),
        .pos_en_in(cur_attr[ATTR_POS]),
        .neg_en_in(cur_attr[ATTR_NEG]),
        .hit_out(hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // point sequencer
    wire cmd_mode = (div_src_act_q == DSRC_CMD);
    wire en_rise = compare_enable_q && !en_prev_q;
    wire trig = active_q && hit;
    wire last_pt = (idx_q == end_pt_q);
    wire [15:0] cyc_nx = cyc_q + 16'h0001;
    wire keep_going = (compare_mode_select_q == MODE_CONT)
        || ((compare_mode_select_q == MODE_NCYC) && (cyc_nx < n_cyc_q));

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            en_prev_q <= 1'b0;
            active_q <= 1'b0;
            idx_q <= RST_POINT;
            cyc_q <= 16'h0000;
        end
        else
        begin
            en_prev_q <= compare_enable_q;
            if (!compare_enable_q || cmd_mode)
                active_q <= 1'b0;
            else if (en_rise)
            begin
                active_q <= 1'b1;
                idx_q <= start_pt_q;
                cyc_q <= 16'h0000;
            end
            else if (trig && last_pt)
            begin
                active_q <= keep_going;
                idx_q <= start_pt_q;
                cyc_q <= cyc_nx;
            end
            else if (trig)
                idx_q <= idx_q + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // delay compensation and pulse timing
    // an early output cannot be produced, so positive compensation clamps to none
    logic [8:0] pend_mask_q;
    logic pend_flip_q;
    logic dly_busy;
    logic dly_done;
    logic pw_busy;
    logic pw_done;
    logic [8:0] flip_lvl_q;
    logic [8:0] pulse_lvl_q;
    wire dly_neg = dly_act_q[15];
    wire [15:0] dly_units = dly_neg ? (16'h0000 - dly_act_q) : 16'h0000;
    wire dly_start = trig && !dly_busy && (dly_units != 16'h0000);
    wire fire_now = trig && (dly_units == 16'h0000);
    wire fire = fire_now || dly_done;
    wire [8:0] fire_mask = fire_now ? cur_attr[ATTR_OUT_LSB +: OUTS] : pend_mask_q;
    wire fire_flip = fire_now ? cur_attr[ATTR_FLIP] : pend_flip_q;
    wire pw_start = fire && !fire_flip;

    pcmp_timer #(
        .UNIT_CYC(DLY_UNIT_CYC)
    ) u_delay (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(dly_start),
        .limit_in(dly_units),
        .busy_out(dly_busy),
        .done_out(dly_done)
    );

    pcmp_timer #(
        .UNIT_CYC(PW_CYC)
    ) u_width (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(pw_start),
        .limit_in(compare_pulse_width_q),
        .busy_out(pw_busy),
        .done_out(pw_done)
    );

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pend_mask_q <= 9'h000;
            pend_flip_q <= 1'b0;
            flip_lvl_q <= 9'h000;
            pulse_lvl_q <= 9'h000;
        end
        else
        begin
            if (dly_start)
            begin
                pend_mask_q <= cur_attr[ATTR_OUT_LSB +: OUTS];
                pend_flip_q <= cur_attr[ATTR_FLIP];
            end
            if (fire && fire_flip)
                flip_lvl_q <= flip_lvl_q ^ fire_mask;
            if (pw_start)
                pulse_lvl_q <= fire_mask;
            else if (pw_done || !pw_busy)
                pulse_lvl_q <= 9'h000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output routing and polarity
    wire [8:0] cmp_lvl = flip_lvl_q ^ pulse_lvl_q;
    logic [2:0] div_base;
    assign div_base = (div_src_act_q == DSRC_MOTOR) ? motor_abz_in
        : (div_src_act_q == DSRC_EXT) ? ext_abz_in
        : (div_src_act_q == DSRC_CMD) ? cmd_abz_in : 3'h0;
    wire [8:0] route = {{3{divider_output_polarity_q[DIVPOL_ROUTE]}}, digital_output_function_config_q[5:0]};
    wire [8:0] pol = {divider_output_polarity_q[2:0], digital_output_function_config_q[DOCFG_POL_LSB +: 6]};
    wire [8:0] idle = {div_base, do_func_in};
    logic [8:0] out_q;

    genvar gi;
    generate
        for (gi = 0; gi < OUTS; gi++)
        begin : g_out
            wire drv = route[gi] ? (cmp_lvl[gi] ^ pol[gi]) : idle[gi];
            always_ff @(posedge clk_in or posedge rst_in)
            begin
                if (rst_in)
                    out_q[gi] <= 1'b0;
                else
                    out_q[gi] <= drv;
            end
        end
    endgenerate

    assign do_out = out_q[5:0];
    assign div_a_out = out_q[6];
    assign div_b_out = out_q[7];
    assign div_z_out = out_q[8];

    ////////////////////////////////////////////////////////////////////////
    // read path
    logic [31:0] rd_mux;
    assign rd_mux = (addr_in == OFS_DIV_SRC) ? {29'h0, divider_source_select_q}
        : (addr_in == OFS_CMP_EN) ? {31'h0, compare_enable_q}
        : (addr_in == OFS_CMP_MODE) ? {30'h0, compare_mode_select_q}
        : (addr_in == OFS_PULSE_W) ? {16'h0, compare_pulse_width_q}
        : (addr_in == OFS_DELAY) ? {16'h0, compare_delay_compensation_q}
        : (addr_in == OFS_START_PT) ? {26'h0, start_pt_q}
        : (addr_in == OFS_END_PT) ? {26'h0, end_pt_q}
        : (addr_in == OFS_N_CYC) ? {16'h0, n_cyc_q}
        : (addr_in == OFS_CMP_SRC) ? {31'h0, cmp_src_q}
        : (addr_in == OFS_DO_CFG) ? {20'h0, digital_output_function_config_q}
        : (addr_in == OFS_DIV_POL) ? {28'h0, divider_output_polarity_q}
        : (addr_in == OFS_STATUS) ? {7'h0, cmp_lvl, 2'h0, idx_q, 5'h0, pw_busy, dly_busy, active_q}
        : (addr_in == OFS_CYC_CNT) ? {16'h0, cyc_q}
        : tgt_hit ? target_q[tgt_rel[IDX_W-1:0]]
        : attr_hit ? {16'h0, attr_q[attr_rel[IDX_W-1:0]]}
        : 32'h00000000;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_q <= 32'h00000000;
        else
            rdata_q <= rd_in ? rd_mux : 32'h00000000;
    end
    assign rdata_out = rdata_q;
endmodule : pcmp_top

// ===== test/pcmp_ctrl_model.sv
// external motion controller model: counts compare pulses on one line and times them
`timescale 1ns/100ps
module pcmp_ctrl_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic line_in,
    output int edges_out,
    output int width_out
);
    int run_q;
    logic last_q;
    // the controller only listens, so nothing is driven back into the unit
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
        begin
            edges_out <= 0;
            width_out <= 0;
            run_q <= 0;
            last_q <= 1'b0;
        end
        else
        begin
            last_q <= line_in;
            run_q <= line_in ? run_q + 1 : 0;
            if (line_in && !last_q)
                edges_out <= edges_out + 1;
            if (!line_in && last_q)
                width_out <= run_q;
        end
endmodule : pcmp_ctrl_model

// ===== test/pcmp_checker.sv
// port assertions of the position compare output unit
`timescale 1ns/100ps
module pcmp_checker (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [pcmp_pkg::ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [31:0] motor_pos_in,
    input wire logic [31:0] ext_pos_in,
    input wire logic [2:0] motor_abz_in,
    input wire logic [2:0] ext_abz_in,
    input wire logic [2:0] cmd_abz_in,
    input wire logic [5:0] do_func_in,
    input wire logic [5:0] do_out,
    input wire logic div_a_out,
    input wire logic div_b_out,
    input wire logic div_z_out
);
    import pcmp_pkg::*;
    logic [15:0] src_w_q, src_a_q, pol_q, cfg_q, en_q, mode_q;
    logic [7:0] st_q;
    wire logic [15:0] wd = wdata_in[15:0];
    wire logic [2:0] div_w = {div_z_out, div_b_out, div_a_out};
    wire logic [2:0] sel_abz = src_a_q[2:0] == DSRC_EXT ? ext_abz_in :
        src_a_q[2:0] == DSRC_CMD ? cmd_abz_in : motor_abz_in;
    // shadows of the settings, divider source only moves on restart
    wire logic [15:0] src_w_d = (wr_in && addr_in == OFS_DIV_SRC) ? wd : src_w_q;
    wire logic [15:0] src_a_d = (wr_in && addr_in == OFS_RESTART) ? src_w_q : src_a_q;
    wire logic [15:0] pol_d = (wr_in && addr_in == OFS_DIV_POL) ? wd : pol_q;
    wire logic [15:0] cfg_d = (wr_in && addr_in == OFS_DO_CFG) ? wd : cfg_q;
    wire logic [15:0] en_d = (wr_in && addr_in == OFS_CMP_EN) ? wd : en_q;
    wire logic [15:0] mode_d = (wr_in && addr_in == OFS_CMP_MODE) ? wd : mode_q;
    // cycles since the last write, saturating
    wire logic [7:0] st_d = wr_in ? 8'h00 : st_q + {7'h00, st_q != 8'hFF};
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            {src_w_q, src_a_q, pol_q, cfg_q, en_q, mode_q, st_q} <= '0;
        else
            {src_w_q, src_a_q, pol_q, cfg_q, en_q, mode_q, st_q} <=
                {src_w_d, src_a_d, pol_d, cfg_d, en_d, mode_d, st_d};
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    rd_idle_a: assert property (!$past(rd_in) || $past(addr_in) == 16'h2000 |-> rdata_out == 32'h0)
        else $error("read data not zero outside a read answer");
    mode_read_a: assert property ($past(rd_in) && $past(addr_in) == OFS_CMP_MODE |-> rdata_out == {16'h0, mode_q})
        else $error("mode readback differs");
    en_read_a: assert property ($past(rd_in) && $past(addr_in) == OFS_CMP_EN |-> rdata_out == {16'h0, en_q})
        else $error("enable readback differs");
    reset_idle_a: assert property ($past(rst_in) |-> do_out == 6'h00 && div_w == 3'h0)
        else $error("outputs not idle after reset");
    do_pass_a: assert property (st_q > 8'h02 |-> ((do_out ^ $past(do_func_in)) & ~cfg_q[5:0] & ~cfg_q[11:6]) == 6'h00)
        else $error("unrouted output does not follow its level");
    div_pass_a: assert property (st_q > 8'h02 && !pol_q[3] && src_a_q[2:0] != DSRC_OFF && src_a_q[2:0] != 3'h2
        |-> div_w == $past(sel_abz))
        else $error("divider output does not follow applied source");
    div_off_a: assert property (st_q > 8'h02 && src_a_q[2:0] == DSRC_OFF && pol_q == 16'h0 |-> div_w == 3'h0)
        else $error("divider output active while prohibited");
    quiet_a: assert property (st_q == 8'hFF && (en_q == 16'h0 || src_a_q[2:0] == DSRC_CMD)
        |-> $stable(do_out & cfg_q[5:0]))
        else $error("compare output moved while comparison is off");
endmodule : pcmp_checker
////////////////////////////////////////////////////////////////////////////////
bind pcmp_top pcmp_checker chk_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .motor_pos_in(motor_pos_in), .ext_pos_in(ext_pos_in),
    .motor_abz_in(motor_abz_in), .ext_abz_in(ext_abz_in), .cmd_abz_in(cmd_abz_in), .do_func_in(do_func_in),
    .do_out(do_out), .div_a_out(div_a_out), .div_b_out(div_b_out), .div_z_out(div_z_out));

// ===== test/pcmp_top_tb.sv
// self-checking bench of the position compare output unit
`timescale 1ns/100ps
module pcmp_top_tb;
    import pcmp_pkg::*;
    localparam int PWC = 4;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [31:0] wdata_in = '0, rdata_out, motor_pos_in = 32'h000000C8, ext_pos_in = '0;
    logic wr_in = 1'b0, rd_in = 1'b0, rd_d = 1'b0, div_a_out, div_b_out, div_z_out;
    logic [2:0] motor_abz_in = '0, ext_abz_in = '0, cmd_abz_in = '0;
    logic [5:0] do_func_in = '0, do_out;
    logic [31:0] q[$];
    int seed = 32'h87632C1A;
    int errors = 0, n_compared = 0, edges, width, lat, l0, e;
    always #25 clk_in = ~clk_in;
    pcmp_top #(.PW_CYC(PWC)) dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .motor_pos_in(motor_pos_in), .ext_pos_in(ext_pos_in),
        .motor_abz_in(motor_abz_in), .ext_abz_in(ext_abz_in), .cmd_abz_in(cmd_abz_in), .do_func_in(do_func_in),
        .do_out(do_out), .div_a_out(div_a_out), .div_b_out(div_b_out), .div_z_out(div_z_out));
    pcmp_ctrl_model ctrl (.clk_in(clk_in), .rst_in(rst_in), .line_in(do_out[0]), .edges_out(edges),
        .width_out(width));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rng(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi)
        begin
            errors++;
            $display("wrong value at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : rng
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] x);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        q.push_back(x);
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask : rd
    // move one position input, then watch 80 cycles for a rising compare output
    task automatic mv(input logic ext, input logic [31:0] p);
        logic prv;
        prv = do_out[0];
        lat = -1;
        @(posedge clk_in);
        if (ext)
            ext_pos_in <= p;
        else
            motor_pos_in <= p;
        for (int i = 0; i < 80; i++)
        begin
            @(posedge clk_in);
            #1;
            if (do_out[0] === 1'b1 && prv === 1'b0 && lat < 0)
                lat = i;
            prv = do_out[0];
        end
    endtask : mv
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in)
    begin
        motor_abz_in <= 3'($random(seed));
        ext_abz_in <= 3'($random(seed));
        cmd_abz_in <= 3'($random(seed));
        do_func_in <= 6'($random(seed)) & 6'h3E;
    end
    // read answers are checked one cycle after the strobe, oldest note first
    always @(posedge clk_in)
    begin
        rd_d <= rd_in;
        if (rd_d && q.size() > 0)
            chk(rdata_out, q.pop_front());
    end
    initial
    begin
        #(50 * 20000);
        errors++;
        results;
    end
    initial
    begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(OFS_DIV_SRC, 32'h0);
        rd(OFS_CMP_EN, 32'h0);
        rd(OFS_CMP_MODE, 32'h0);
        rd(OFS_PULSE_W, {16'h0, RST_PULSE_W});
        rd(OFS_DELAY, 32'h0);
        rd(16'h2000, 32'h0);
        wr(OFS_TGT_BASE, 32'h00000064);
        wr(OFS_TGT_BASE + 16'h0001, 32'h00000032);
        wr(OFS_ATTR_BASE, 32'h00000081);
        wr(OFS_ATTR_BASE + 16'h0001, 32'h00000142);
        wr(OFS_DO_CFG, 32'h3);
        wr(OFS_PULSE_W, 32'h3);
        wr(OFS_CMP_MODE, {30'h0, MODE_CONT});
        wr(OFS_END_PT, 32'h2);
        wr(OFS_CMP_EN, 32'h1);
        rd(OFS_CMP_MODE, {30'h0, MODE_CONT});
        mv(0, 32'h0);
        rng(edges, 0, 0);
        mv(0, 32'h96);
        l0 = lat;
        rng(edges, 1, 1);
        rng(width, 3 * PWC, 3 * PWC + 1);
        mv(0, 32'h0);
        chk({31'h0, do_out[1]}, 32'h1);
        mv(0, 32'h96);
        mv(0, 32'h0);
        rng(edges, 2, 2);
        chk({31'h0, do_out[1]}, 32'h0);
        wr(OFS_PULSE_W, 32'h0);
        mv(0, 32'h96);
        rng(width, 1, 2);
        wr(OFS_CMP_EN, 32'h0);
        wr(OFS_CMP_MODE, {30'h0, MODE_SINGLE});
        wr(OFS_END_PT, 32'h1);
        wr(OFS_PULSE_W, 32'h3);
        mv(0, 32'h0);
        wr(OFS_CMP_EN, 32'h1);
        for (int i = 0; i < 2; i++)
        begin
            mv(0, 32'h96);
            mv(0, 32'h0);
        end
        rng(edges, 4, 4);
        wr(OFS_CMP_EN, 32'h0);
        wr(OFS_CMP_MODE, {30'h0, MODE_NCYC});
        wr(OFS_N_CYC, 32'h2);
        wr(OFS_CMP_EN, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            mv(0, 32'h96);
            mv(0, 32'h0);
            e = (i < 2) ? 5 + i : 6;
            rng(edges, e, e);
        end
        wr(OFS_CMP_EN, 32'h0);
        wr(OFS_CMP_MODE, {30'h0, MODE_CONT});
        wr(OFS_CMP_SRC, 32'h1);
        wr(OFS_CMP_EN, 32'h1);
        mv(0, 32'h96);
        rng(edges, 6, 6);
        mv(1, 32'h96);
        rng(edges, 7, 7);
        wr(OFS_CMP_SRC, 32'h0);
        wr(OFS_DELAY, 32'h0000FFFB);
        wr(OFS_CMP_EN, 32'h0);
        mv(0, 32'h0);
        wr(OFS_CMP_EN, 32'h1);
        mv(0, 32'h96);
        rng(lat, l0, l0);
        wr(OFS_RESTART, 32'h1);
        mv(0, 32'h0);
        mv(0, 32'h96);
        rng(lat - l0, 5 * DLY_UNIT_CYC, 5 * DLY_UNIT_CYC + 1);
        wr(OFS_DO_CFG, 32'h43);
        repeat (4) @(posedge clk_in);
        chk({31'h0, do_out[0]}, 32'h1);
        wr(OFS_DO_CFG, 32'h3);
        wr(OFS_DIV_SRC, 32'h1);
        rd(OFS_DIV_SRC, 32'h1);
        wr(OFS_RESTART, 32'h1);
        wr(OFS_DIV_SRC, 32'h3);
        wr(OFS_RESTART, 32'h1);
        mv(0, 32'h0);
        mv(0, 32'h96);
        rng(edges, 10, 10);
        repeat (300) @(posedge clk_in);
        wr(OFS_DIV_SRC, 32'h4);
        wr(OFS_RESTART, 32'h1);
        repeat (4) @(posedge clk_in);
        chk({29'h0, div_z_out, div_b_out, div_a_out}, 32'h0);
        results;
    end
endmodule : pcmp_top_tb
